// ---- logic/current_power_calc_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// RL1 - Power result register, offset 03h, resets zero
// RL2 - Power equals current times bus over 5000
// RL3 - Current result at 04h, two's complement
// RL4 - Current equals shunt reading times calibration
// RL5 - Calibration at 05h; D15..D1 used only
// RL6 - Calibration D0 always reads zero
// RL7 - Calibration clears to zero at reset
// RL8 - Host picks calibration, sets full scale
// RL9 - Reading power result clears conversion ready
// RL10 - Out-of-range current or power sets overflow
// RL11 - Ready set only after multiplications complete
// RL12 - Recompute both results on each conversion; the code ignores conv_done_in while busy_out is high
module current_power_calc_regs
  import pwr_calc_pkg::*;
(
  input  wire logic        clk_sys_in,          // System clock, 100 MHz
  input  wire logic        rst_n_in,            // Asynchronous reset, active low
  input  wire reg_req_s    reg_req_in,          // Register access from the serial engine
  output reg_rsp_s         reg_rsp_out,         // Registered read answer
  input  wire logic        conv_done_in,        // Pulse: new shunt and bus readings stored
  input  wire logic [15:0] shunt_reading_in,    // Signed shunt voltage reading
  input  wire logic [12:0] bus_reading_in,      // Unsigned bus voltage reading
  input  wire logic        ready_clear_in,      // Pulse: operating mode rewritten
  output logic             conversion_ready_flag_out, // Results complete
  output logic             math_overflow_flag_out,    // Last result out of range
  output logic             busy_out             // Calculation in progress
);

  // ***************************************************************
  // Register file state
  // ***************************************************************
  logic [15:0] power_result;       // Read-only power
  logic [15:0] current_result;     // Read-only current
  logic [15:0] calibration_value;  // Software calibration, bit 0 void
  logic        conversion_ready_flag;
  logic        math_overflow_flag;
  reg_rsp_s    rsp;                // Registered answer
  logic [15:0] next_power_result;
  logic [15:0] next_current_result;
  logic [15:0] next_calibration_value;
  logic        next_conversion_ready_flag;
  logic        next_math_overflow_flag;
  reg_rsp_s    next_rsp;

  // ***************************************************************
  // Calculation state
  // ***************************************************************
  calc_state_e state;              // Sequencer
  calc_state_e next_state;
  logic [12:0] bus_hold;           // Bus reading captured at start
  logic [15:0] shunt_hold;         // Shunt reading captured at start; the pin may move on
  logic        cur_ovf;            // Current overflow seen this pass
  logic        div_start;          // Held low and unused; div_go kicks the divider
  logic [31:0] div_dividend;       // Magnitude of current times bus
  logic        div_done;           // Divider finished
  logic [31:0] div_quot;           // Divider quotient
  logic [12:0] next_bus_hold;
  logic [15:0] next_shunt_hold;
  logic        next_cur_ovf;

  // ***************************************************************
  // Combinational arithmetic
  // ***************************************************************
  logic signed [31:0] cur_full;    // Shunt times calibration, before scaling
  logic signed [31:0] cur_scaled;  // Scaled current
  logic        [15:0] cur_mag;     // Magnitude of stored current
  logic        [31:0] pwr_mag;     // Magnitude of power

  // Calibration word D15..D1 is the multiplier; dividing the product by 2048 keeps
  // the usual current_lsb relation while D0 plays no part at all
  always_comb begin
    cur_full   = $signed(shunt_hold) * $signed({17'h00000, calibration_value[15:1]}); // RL4 RL5
    cur_scaled = cur_full >>> 11;
    cur_mag    = current_result[CURRENT_SIGN_POS] ? 16'(-current_result) : current_result; // RL3
    div_dividend = 32'(cur_mag) * 32'(bus_hold); // RL2
    pwr_mag    = div_quot;
  end

  // ***************************************************************
  // Sequencer: capture, multiply, divide
  // ***************************************************************
  always_comb begin
    next_state          = state;
    next_bus_hold       = bus_hold;
    next_shunt_hold     = shunt_hold;
    next_cur_ovf        = cur_ovf;
    next_current_result = current_result;
    next_power_result   = power_result;
    div_start           = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (conv_done_in) begin // RL12
          next_bus_hold   = bus_reading_in;
          next_shunt_hold = shunt_reading_in;
          next_state    = ST_MUL;
        end
      end
      ST_MUL: begin
        // Saturate rather than wrap, and remember the event
        if (cur_scaled > 32'sd32767) begin
          next_current_result = 16'h7fff;
          next_cur_ovf        = 1'b1; // RL10
        end else if (cur_scaled < -32'sd32768) begin
          next_current_result = 16'h8000;
          next_cur_ovf        = 1'b1; // RL10
        end else begin
          next_current_result = cur_scaled[15:0]; // RL4
          next_cur_ovf        = 1'b0;
        end
        next_state   = ST_DIV;
      end
      ST_DIV: begin
        if (div_done) begin
          // Power is kept as a magnitude; a negative current gives its absolute power
          next_power_result = (pwr_mag > 32'h0000ffff) ? 16'hffff : pwr_mag[15:0]; // RL2
          next_state        = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Divider launch is one cycle after the current result settles
  logic div_go;                // Start pulse toward the divider
  logic div_step_first;        // First cycle of the divide state
  logic next_div_step_first;
  assign div_go              = (state == ST_DIV) && (div_step_first);
  assign next_div_step_first = (state == ST_MUL);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state          <= ST_IDLE;
      bus_hold       <= 13'h0000;
      shunt_hold     <= 16'h0000;
      cur_ovf        <= 1'b0;
      div_step_first <= 1'b0;
    end else begin
      state          <= next_state;
      bus_hold       <= next_bus_hold;
      shunt_hold     <= next_shunt_hold;
      cur_ovf        <= next_cur_ovf;
      div_step_first <= next_div_step_first;
    end
  end

  unsigned_divider u_div (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .start_in     (div_go),
    .dividend_in  (div_dividend),
    .divisor_in   (POWER_DIVISOR),
    .done_out     (div_done),
    .quotient_out (div_quot)
  );

  // ***************************************************************
  // Register access and flags
  // ***************************************************************
  logic calc_finish;   // Last step of a pass
  logic pwr_read;      // Host reads the power result
  assign calc_finish = (state == ST_DIV) && div_done;
  assign pwr_read    = reg_req_in.req && !reg_req_in.write && (reg_req_in.addr == POWER_RESULT_OFFSET);

  always_comb begin
    next_calibration_value     = calibration_value;
    next_conversion_ready_flag = conversion_ready_flag;
    next_math_overflow_flag    = math_overflow_flag;
    next_rsp                   = rsp;
    // Writes reach the calibration word only; D0 cannot be set
    if (reg_req_in.req && reg_req_in.write && (reg_req_in.addr == CALIBRATION_VALUE_OFFSET)) begin
      next_calibration_value = reg_req_in.wdata & CAL_WRITE_MASK; // RL6
    end
    // Reads answer the next cycle; unmapped offsets read zero with ok low
    if (reg_req_in.req && !reg_req_in.write) begin
      next_rsp.ok = 1'b1;
      unique case (reg_req_in.addr)
        POWER_RESULT_OFFSET:      next_rsp.rdata = power_result; // RL1
        CURRENT_RESULT_OFFSET:    next_rsp.rdata = current_result; // RL3
        CALIBRATION_VALUE_OFFSET: next_rsp.rdata = calibration_value; // RL5
        default: begin
          next_rsp.ok    = 1'b0;
          next_rsp.rdata = 16'h0000;
        end
      endcase
    end
    // Clears first, so a completing pass in the same cycle still sets the flag
    if (pwr_read || ready_clear_in) begin
      next_conversion_ready_flag = 1'b0; // RL9
    end
    if (calc_finish) begin
      next_conversion_ready_flag = 1'b1; // RL11
      next_math_overflow_flag    = cur_ovf || (pwr_mag > 32'h0000ffff); // RL10
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_result          <= POWER_RESULT_RESET; // RL1
      current_result        <= CURRENT_RESULT_RESET;
      calibration_value     <= CALIBRATION_VALUE_RESET; // RL7
      conversion_ready_flag <= 1'b0;
      math_overflow_flag    <= 1'b0;
      rsp                   <= '0;
    end else begin
      power_result          <= next_power_result;
      current_result        <= next_current_result;
      calibration_value     <= next_calibration_value;
      conversion_ready_flag <= next_conversion_ready_flag;
      math_overflow_flag    <= next_math_overflow_flag;
      rsp                   <= next_rsp;
    end
  end

  assign reg_rsp_out               = rsp;
  assign conversion_ready_flag_out = conversion_ready_flag;
  assign math_overflow_flag_out    = math_overflow_flag;
  assign busy_out                  = (state != ST_IDLE);

endmodule : current_power_calc_regs

// ---- include/pwr_calc_pkg.sv ----
package pwr_calc_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0]  POWER_RESULT_OFFSET      = 8'h03;
  localparam logic [7:0]  CURRENT_RESULT_OFFSET    = 8'h04;
  localparam logic [7:0]  CALIBRATION_VALUE_OFFSET = 8'h05;

  // ***************************************************************
  // Reset values and field layout
  // ***************************************************************
  localparam logic [15:0] POWER_RESULT_RESET       = 16'h0000;
  localparam logic [15:0] CURRENT_RESULT_RESET     = 16'h0000;
  localparam logic [15:0] CALIBRATION_VALUE_RESET  = 16'h0000;
  localparam int          CURRENT_SIGN_POS         = 15;
  localparam int          CAL_VOID_POS             = 0;
  localparam logic [15:0] CAL_WRITE_MASK           = 16'hfffe;

  // ***************************************************************
  // Arithmetic constants and timing
  // ***************************************************************
  localparam logic [15:0] POWER_DIVISOR            = 16'h1388;  // 5000
  localparam int          DIV_STEPS                = 32;        // Restoring divider, one quotient bit a cycle

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic        req;    // One-cycle access strobe
    logic        write;  // High for a write
    logic [7:0]  addr;   // Register offset
    logic [15:0] wdata;  // Write data
  } reg_req_s;

  typedef struct packed {
    logic        ok;     // High when the offset is mapped here
    logic [15:0] rdata;  // Read data, registered
  } reg_rsp_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MUL  = 3'b010,
    ST_DIV  = 3'b100
  } calc_state_e;

endpackage : pwr_calc_pkg

// ---- logic/unsigned_divider.sv ----
`timescale 1ns/1ps
module unsigned_divider
  import pwr_calc_pkg::*;
(
  input  wire logic        clk_sys_in,   // System clock
  input  wire logic        rst_n_in,     // Asynchronous reset, active low
  input  wire logic        start_in,     // One-cycle start pulse
  input  wire logic [31:0] dividend_in,  // Magnitude to divide
  input  wire logic [15:0] divisor_in,   // Divisor, non-zero
  output logic             done_out,     // One-cycle pulse when quotient is ready
  output logic      [31:0] quotient_out  // Quotient, held until the next start
);

  // ***************************************************************
  // Restoring division state
  // ***************************************************************
  logic [31:0] quot;        // Shifts in quotient bits
  logic [16:0] rem;         // Partial remainder
  logic [5:0]  count;       // Steps left
  logic        done;        // Completion pulse
  logic [31:0] next_quot;
  logic [16:0] next_rem;
  logic [5:0]  next_count;
  logic        next_done;
  logic [16:0] trial;       // Remainder with next dividend bit

  // Next-state logic; one bit per cycle keeps the area small at the cost of latency
  always_comb begin
    next_quot  = quot;
    next_rem   = rem;
    next_count = count;
    next_done  = 1'b0;
    trial      = {rem[15:0], quot[31]};
    if (start_in) begin
      next_quot  = dividend_in;
      next_rem   = 17'h00000;
      next_count = 6'(DIV_STEPS);
    end else if (count != 6'h00) begin
      if (trial >= {1'b0, divisor_in}) begin
        next_rem  = trial - {1'b0, divisor_in};
        next_quot = {quot[30:0], 1'b1};
      end else begin
        next_rem  = trial;
        next_quot = {quot[30:0], 1'b0};
      end
      next_count = count - 6'h01;
      next_done  = (count == 6'h01);
    end
  end

  // Registers only
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quot  <= 32'h00000000;
      rem   <= 17'h00000;
      count <= 6'h00;
      done  <= 1'b0;
    end else begin
      quot  <= next_quot;
      rem   <= next_rem;
      count <= next_count;
      done  <= next_done;
    end
  end

  assign done_out     = done;
  assign quotient_out = quot;

endmodule : unsigned_divider

// ---- tb/calc_host_model.sv ----
`timescale 1ns/1ps
module calc_host_model
  import pwr_calc_pkg::*;
(
  input  wire logic     clk_sys_in, // System clock
  input  wire reg_rsp_s rsp_in,     // Answer from the block
  output reg_req_s      req_out     // Access toward the block
);
  // ****************************************
  // Register accesses
  // ****************************************
  initial req_out = '0;
  // One access; fields are inverted while idle so a stale address is never mistaken for a live one
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, output reg_rsp_s r);
    @(posedge clk_sys_in);
    #1 req_out = {1'b1, wr, a, d};
    @(posedge clk_sys_in);
    #1 req_out = {1'b0, ~wr, ~a, ~d};
    @(posedge clk_sys_in);
    #1 r = rsp_in;
  endtask : access
endmodule : calc_host_model

// ---- tb/calc_assertions.sv ----
`timescale 1ns/1ps
module calc_assertions
  import pwr_calc_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire reg_req_s    reg_req_in,
  input wire reg_rsp_s    reg_rsp_out,
  input wire logic        conv_done_in,
  input wire logic        ready_clear_in,
  input wire logic        conversion_ready_flag_out,
  input wire logic        math_overflow_flag_out,
  input wire logic        busy_out
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Read strobes decoded once
  wire logic rd_any = reg_req_in.req && !reg_req_in.write;
  busy_start_a: assert property (conv_done_in && !busy_out |=> busy_out)
    else $error("busy did not follow a conversion");
  busy_run_a: assert property ($rose(busy_out) |-> busy_out[*8] ##[1:40] !busy_out)
    else $error("calculation length out of range");
  ready_late_a: assert property ($rose(conversion_ready_flag_out) |-> $past(busy_out))
    else $error("ready set without a calculation");
  ready_rd_a: assert property (rd_any && reg_req_in.addr == POWER_RESULT_OFFSET && !busy_out
    |=> !conversion_ready_flag_out)
    else $error("power read left ready set");
  ready_mode_a: assert property (ready_clear_in && !busy_out |=> !conversion_ready_flag_out)
    else $error("mode rewrite left ready set");
  unmapped_rd_a: assert property (rd_any && (reg_req_in.addr < 8'h03 || reg_req_in.addr > 8'h05)
    |=> !reg_rsp_out.ok && reg_rsp_out.rdata == 16'h0000)
    else $error("unmapped read answered");
  cal_void_a: assert property (rd_any && reg_req_in.addr == CALIBRATION_VALUE_OFFSET
    |=> reg_rsp_out.ok && !reg_rsp_out.rdata[0])
    else $error("calibration bit zero set");
  rsp_hold_a: assert property (!rd_any |=> $stable(reg_rsp_out))
    else $error("answer changed without a read");
  ovf_time_a: assert property ($changed(math_overflow_flag_out) |-> $past(busy_out))
    else $error("overflow changed outside a pass");
  // Main scenarios reached
  cover property ($rose(conversion_ready_flag_out));
  cover property ($rose(math_overflow_flag_out));
  cover property (conv_done_in && busy_out);
endmodule : calc_assertions
bind current_power_calc_regs calc_assertions u_chk (.clk_sys_in, .rst_n_in, .reg_req_in, .reg_rsp_out,
  .conv_done_in, .ready_clear_in, .conversion_ready_flag_out, .math_overflow_flag_out, .busy_out);

// ---- tb/tb_current_power_calc_regs.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_current_power_calc_regs;
  import pwr_calc_pkg::*;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, conv_done_in = 1'b0, ready_clear_in = 1'b0;
  logic [15:0] shunt_reading_in = 16'h0000; // Signed shunt sample
  logic [12:0] bus_reading_in = 13'h0000;   // Bus sample
  reg_req_s    reg_req_in;
  reg_rsp_s    reg_rsp_out, r;
  logic        conversion_ready_flag_out, math_overflow_flag_out, busy_out;
  int          fail_count = 0, samples_checked = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  current_power_calc_regs u_dut (.clk_sys_in, .rst_n_in, .reg_req_in, .reg_rsp_out, .conv_done_in,
    .shunt_reading_in, .bus_reading_in, .ready_clear_in, .conversion_ready_flag_out,
    .math_overflow_flag_out, .busy_out);
  calc_host_model u_host (.clk_sys_in, .rsp_in(reg_rsp_out), .req_out(reg_req_in));
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic k);
    u_host.access(1'b0, a, 16'h0000, r);
    `CHK("read data", e, r.rdata)
    `CHK("hit", k, r.ok)
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d, r);
  endtask : wr
  // Start a pass; an optional second pulse lands mid-run and must be ignored
  task automatic conv(input logic [15:0] s, input logic [12:0] b, input logic dup);
    @(posedge clk_sys_in);
    #1 {conv_done_in, shunt_reading_in, bus_reading_in} = {1'b1, s, b};
    @(posedge clk_sys_in);
    #1 {conv_done_in, shunt_reading_in, bus_reading_in} = {dup, dup ? 16'h0001 : ~s, ~b};
    `CHK("busy", 1'b1, busy_out)
    if (dup) begin
      @(posedge clk_sys_in) #1 conv_done_in = 1'b0;
    end
    for (int i = 0; i < 60 && busy_out !== 1'b0; i++) @(posedge clk_sys_in) #1;
    `CHK("done", 1'b0, busy_out)
  endtask : conv
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdc(POWER_RESULT_OFFSET, 16'h0000, 1'b1);
    rdc(CURRENT_RESULT_OFFSET, 16'h0000, 1'b1);
    rdc(CALIBRATION_VALUE_OFFSET, 16'h0000, 1'b1);
    rdc(8'h06, 16'h0000, 1'b0);
    `CHK("ready", 1'b0, conversion_ready_flag_out)
    $display("test reset done");
  endtask : t_reset
  task automatic t_cal;
    wr(CALIBRATION_VALUE_OFFSET, 16'hffff);
    rdc(CALIBRATION_VALUE_OFFSET, 16'hfffe, 1'b1);
    wr(POWER_RESULT_OFFSET, 16'h1234);
    rdc(POWER_RESULT_OFFSET, 16'h0000, 1'b1);
    wr(CURRENT_RESULT_OFFSET, 16'h1234);
    rdc(CURRENT_RESULT_OFFSET, 16'h0000, 1'b1);
    $display("test calibration done");
  endtask : t_cal
  // Calibration 1000h gives unit gain: 8000 x 8000 / 5000 = 12800
  task automatic t_pos;
    wr(CALIBRATION_VALUE_OFFSET, 16'h1000);
    conv(16'h1f40, 13'h1f40, 1'b0);
    `CHK("ready", 1'b1, conversion_ready_flag_out)
    `CHK("overflow", 1'b0, math_overflow_flag_out)
    rdc(CURRENT_RESULT_OFFSET, 16'h1f40, 1'b1);
    rdc(POWER_RESULT_OFFSET, 16'h3200, 1'b1);
    `CHK("ready", 1'b0, conversion_ready_flag_out)
    $display("test positive done");
  endtask : t_pos
  // -32000 keeps its sign; power uses magnitude: 32000 x 100 / 5000 = 640
  task automatic t_neg;
    conv(16'h8300, 13'h0064, 1'b0);
    @(posedge clk_sys_in) #1 ready_clear_in = 1'b1;
    @(posedge clk_sys_in) #1 ready_clear_in = 1'b0;
    `CHK("ready", 1'b0, conversion_ready_flag_out)
    rdc(CURRENT_RESULT_OFFSET, 16'h8300, 1'b1);
    rdc(POWER_RESULT_OFFSET, 16'h0280, 1'b1);
    $display("test negative done");
  endtask : t_neg
  // Largest gain saturates current; power 32767 x 8191 / 5000 = 53678
  // Then the negative end: current pins at 8000h, power 32768 x 5000 / 5000 = 32768
  task automatic t_ovf;
    wr(CALIBRATION_VALUE_OFFSET, 16'hfffe);
    conv(16'h7fff, 13'h1fff, 1'b1);
    `CHK("overflow", 1'b1, math_overflow_flag_out)
    rdc(CURRENT_RESULT_OFFSET, 16'h7fff, 1'b1);
    rdc(POWER_RESULT_OFFSET, 16'hd1ae, 1'b1);
    conv(16'h8001, 13'h1388, 1'b0);
    `CHK("overflow", 1'b1, math_overflow_flag_out)
    rdc(CURRENT_RESULT_OFFSET, 16'h8000, 1'b1);
    rdc(POWER_RESULT_OFFSET, 16'h8000, 1'b1);
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_rerst;
    @(posedge clk_sys_in) #1 rst_n_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    `CHK("overflow", 1'b0, math_overflow_flag_out)
    rdc(CALIBRATION_VALUE_OFFSET, 16'h0000, 1'b1);
    rdc(CURRENT_RESULT_OFFSET, 16'h0000, 1'b1);
    $display("test second reset done");
  endtask : t_rerst
  // ****************************************
  // Run control
  // ****************************************
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    t_reset();
    t_cal();
    t_pos();
    t_neg();
    t_ovf();
    t_rerst();
    conclude();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
endmodule : tb_current_power_calc_regs
